// ===== common/rom_cfg_pkg.sv
// Constants and types shared by the configuration pin block
package rom_cfg_pkg;
  localparam int CLK_PERIOD_NS = 4;
  // Serial clock periods per serial ROM speed setting
  localparam int SLOW_PERIOD_NS = 4000;
  localparam int FAST_PERIOD_NS = 800;
  localparam int MID_LO_PERIOD_NS = 1600;
  localparam int MID_HI_PERIOD_NS = 3200;
  localparam int DIV_W = 10;
  localparam logic [DIV_W-1:0] SLOW_HALF = DIV_W'(SLOW_PERIOD_NS / (2 * CLK_PERIOD_NS));
  localparam logic [DIV_W-1:0] FAST_HALF = DIV_W'(FAST_PERIOD_NS / (2 * CLK_PERIOD_NS));
  localparam logic [DIV_W-1:0] MID_LO_HALF = DIV_W'(MID_LO_PERIOD_NS / (2 * CLK_PERIOD_NS));
  localparam logic [DIV_W-1:0] MID_HI_HALF = DIV_W'(MID_HI_PERIOD_NS / (2 * CLK_PERIOD_NS));
  localparam logic [1:0] SPEED_FAST = 2'h0;
  localparam logic [1:0] SPEED_MID_LO = 2'h1;
  localparam logic [1:0] SPEED_MID_HI = 2'h2;
  localparam logic [1:0] SPEED_SLOW = 2'h3;
  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_TX = 8'h08;
  localparam logic [7:0] ADDR_RX = 8'h0c;
  // Field positions
  localparam int CTRL_SPEED_LSB = 0;
  localparam int CTRL_GO_BIT = 2;
  localparam int CTRL_LEN_LSB = 8;
  localparam int ST_PRESENT_BIT = 0;
  localparam int ST_BIG_END_BIT = 1;
  localparam int ST_BUSY_BIT = 2;
  localparam int ST_DONE_BIT = 3;
  localparam int ST_ASLEEP_BIT = 4;
  localparam int ST_REFUSED_BIT = 5;
  localparam int ST_WR_CNT_LSB = 16;
  localparam int ST_IGN_CNT_LSB = 24;
  // Reset values
  localparam logic [1:0] SPEED_RESET = 2'h0;
  localparam logic [4:0] LEN_RESET = 5'h1f;
  localparam logic [31:0] TX_RESET = 32'h0000_0000;
  // Synchroniser lanes
  localparam int SYN_W = 6;
  localparam int SYN_PRESENT = 0;
  localparam int SYN_SCLK = 1;
  localparam int SYN_DIN = 2;
  localparam int SYN_QUAL = 3;
  localparam int SYN_WR = 4;
  localparam int SYN_AWAKE = 5;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SHIFT = 3'b010,
    ST_END = 3'b100
  } eng_state_t;
endpackage

// ===== sim/serial_rom_model.sv
// Serial configuration ROM model facing the loader's serial pins
`timescale 1ns/1ps
module serial_rom_model #(
  parameter logic [31:0] ROM_WORD = 32'h9b00_0000
) (
  input wire logic select_i,
  input wire logic sclk_i,
  input wire logic din_i,
  output logic dout_o,
  output logic [31:0] rx_o
);
  int idx = 0;
  initial begin
    rx_o = 32'h0;
  end
  always @(posedge select_i) begin
    idx = 0;
    rx_o = 32'h0;
  end
  // Next bit after the falling edge, so the rising edge sees it settled
  always @(negedge sclk_i) begin
    if (select_i) begin
      idx = idx + 1;
    end
  end
  always @(posedge sclk_i) begin
    if (select_i) begin
      rx_o = {rx_o[30:0], din_i};
    end
  end
  // Pulled down when not selected
  assign dout_o = select_i ? ROM_WORD[5'(31 - idx)] : 1'b0;
endmodule

// ===== sim/test_eeprom_strap_config_pins.sv
// Self-checking bench for the configuration pin block
`timescale 1ns/1ps
module test_eeprom_strap_config_pins;
  import rom_cfg_pkg::*;
  localparam logic [31:0] ROM_W = 32'h9b00_0000;
  localparam logic [31:0] TX_W = 32'ha5c3_0000;
  logic clock_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic present = 1'b0, sk_pull = 1'b0, qual_n = 1'b1, wr_n = 1'b1, sleep_n = 1'b1;
  wire [31:0] rdat, mrx;
  wire ack, sk, sk_oe, sel, sel_oe, dout, dout_oe, din, ce, big, asleep;
  // The clock pin is two-way: strap pull wins while the block does not drive it
  wire sk_pin = sk_oe ? sk : sk_pull;
  int n_fail = 0;
  int compares = 0;
  logic [31:0] rd;
  int n;

  initial begin
    forever #2 clock_i = ~clock_i;
  end

  rom_cfg_pins dut_u (.clock_i(clock_i), .rst_n_i(rst_n_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .rom_present_strap_i(present), .serial_rom_clock_i(sk_pin),
    .serial_rom_clock_o(sk), .serial_rom_clock_oe_o(sk_oe), .serial_rom_select_o(sel),
    .serial_rom_select_oe_o(sel_oe), .serial_rom_data_out_o(dout),
    .serial_rom_data_out_oe_o(dout_oe), .serial_rom_data_in_i(din),
    .access_qualifier_n_i(qual_n), .write_strobe_n_i(wr_n), .chip_sleep_n_i(sleep_n),
    .chip_enable_o(ce), .big_endian_o(big), .asleep_o(asleep));

  serial_rom_model #(.ROM_WORD(ROM_W)) rom_u (.select_i(sel), .sclk_i(sk_pin),
    .din_i(dout), .dout_o(din), .rx_o(mrx));

  task automatic final_report();
    $display("checks %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic cyc_n(input int k);
    repeat (k) @(posedge clock_i);
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    k = 0;
    do begin
      @(posedge clock_i);
      k++;
    end while (ack !== 1'b1 && k < 50);
    if (k >= 50) begin
      chk("wishbone ack", 32'h1, 32'h0);
      final_report();
    end
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clock_i);
  endtask

  // Waits until the picked output reaches a level, counting cycles
  task automatic wait_lv(input bit pick_sel, input logic lv, output int c);
    c = 0;
    do begin
      @(posedge clock_i);
      c++;
    end while ((pick_sel ? sel : sk) !== lv && c < 5000);
    if (c >= 5000) begin
      chk("serial wait", 32'h1, 32'h0);
      final_report();
    end
  endtask

  task automatic do_reset(input logic p, input logic b);
    present <= p;
    sk_pull <= b;
    rst_n_i <= 1'b0;
    cyc_n(4);
    rst_n_i <= 1'b1;
    cyc_n(2);
  endtask

  task automatic t_straps();
    for (int p = 0; p < 2; p++) begin
      do_reset(p[0], p[0]);
      chk("big endian", {31'h0, p[0]}, {31'h0, big});
      chk("clock oe", {31'h0, p[0]}, {31'h0, sk_oe});
      wb(1'b1, ADDR_CTRL, 32'h0000_0704);
      cyc_n(3);
      chk("select", {31'h0, p[0]}, {31'h0, sel});
      wb(1'b0, ADDR_STATUS, 32'h0);
      chk("status straps", {30'h0, p[0], p[0]}, {30'h0, rd[1:0]});
      chk("refused", {31'h0, ~p[0]}, {31'h0, rd[ST_REFUSED_BIT]});
      wait_lv(1'b1, 1'b0, n);
      wb(1'b0, ADDR_RX, 32'h0);
      if (!p[0]) begin
        chk("rx without rom", 32'h0, rd);
      end
    end
  endtask

  task automatic t_xfer(input logic [1:0] spd, input int bits, input int period);
    logic [31:0] m;
    int a;
    int b;
    m = (32'h1 << bits) - 32'h1;
    wb(1'b1, ADDR_TX, TX_W);
    wb(1'b1, ADDR_CTRL, {19'h0, 5'(bits - 1), 6'h01, spd});
    wait_lv(1'b0, 1'b1, n);
    wait_lv(1'b0, 1'b0, a);
    wait_lv(1'b0, 1'b1, b);
    chk("clock period", period, a + b);
    wait_lv(1'b1, 1'b0, n);
    cyc_n(2);
    chk("rom received", (TX_W >> (32 - bits)) & m, mrx & m);
    wb(1'b0, ADDR_RX, 32'h0);
    chk("rx word", (ROM_W >> (32 - bits)) & m, rd & m);
    wb(1'b0, ADDR_STATUS, 32'h0);
    chk("done", 32'h1, {31'h0, rd[ST_DONE_BIT]});
    wb(1'b1, ADDR_STATUS, 32'h0000_0028);
  endtask

  task automatic strobe();
    wr_n <= 1'b0;
    cyc_n(4);
    wr_n <= 1'b1;
    cyc_n(4);
  endtask

  task automatic t_strobes();
    qual_n <= 1'b0;
    cyc_n(4);
    chk("chip enable low qual", 32'h1, {31'h0, ce});
    strobe();
    qual_n <= 1'b1;
    cyc_n(4);
    chk("chip enable high qual", 32'h0, {31'h0, ce});
    strobe();
    strobe();
    wb(1'b0, ADDR_STATUS, 32'h0);
    chk("write counts", 32'h0201, {16'h0, rd[31:16]});
  endtask

  task automatic t_sleep();
    wb(1'b1, ADDR_CTRL, 32'h0000_1f04);
    cyc_n(300);
    sleep_n <= 1'b0;
    cyc_n(5);
    chk("asleep", 32'h1, {31'h0, asleep});
    chk("all oe", 32'h0, {29'h0, sk_oe, sel_oe, dout_oe});
    chk("select aborted", 32'h0, {31'h0, sel});
    wb(1'b0, ADDR_STATUS, 32'h0);
    chk("sleep status", 32'h2, {30'h0, rd[ST_ASLEEP_BIT], rd[ST_DONE_BIT]});
    sleep_n <= 1'b1;
    cyc_n(5);
    chk("awake oe", 32'h7, {29'h0, sk_oe, sel_oe, dout_oe});
  endtask

  initial begin
    t_straps();
    t_xfer(SPEED_FAST, 8, 200);
    t_xfer(SPEED_SLOW, 2, 1000);
    t_strobes();
    t_sleep();
    final_report();
  end
endmodule

// ===== src/rom_cfg_pins.sv
// Configuration pin block: serial ROM loader, strap capture, host qualifiers, sleep
`timescale 1ns/1ps
module rom_cfg_pins
  import rom_cfg_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic rom_present_strap_i,
  input wire logic serial_rom_clock_i,
  output logic serial_rom_clock_o,
  output logic serial_rom_clock_oe_o,
  output logic serial_rom_select_o,
  output logic serial_rom_select_oe_o,
  output logic serial_rom_data_out_o,
  output logic serial_rom_data_out_oe_o,
  input wire logic serial_rom_data_in_i,
  input wire logic access_qualifier_n_i,
  input wire logic write_strobe_n_i,
  input wire logic chip_sleep_n_i,
  output logic chip_enable_o,
  output logic big_endian_o,
  output logic asleep_o
);

  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0] sel);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic [DIV_W-1:0] half_of(input logic [1:0] speed);
    logic [DIV_W-1:0] h;
    unique case (speed)
      SPEED_FAST: h = FAST_HALF;
      SPEED_MID_LO: h = MID_LO_HALF;
      SPEED_MID_HI: h = MID_HI_HALF;
      SPEED_SLOW: h = SLOW_HALF;
    endcase
    return h;
  endfunction

  // Pin synchronisers; first stage feeds only the second
  logic [SYN_W-1:0] pin_raw;
  logic [SYN_W-1:0] sync1;
  logic [SYN_W-1:0] sync2;
  assign pin_raw = {chip_sleep_n_i, write_strobe_n_i, access_qualifier_n_i,
                    serial_rom_data_in_i, serial_rom_clock_i, rom_present_strap_i};

  genvar g;
  generate
    for (g = 0; g < SYN_W; g++) begin : g_sync
      always_ff @(posedge clock_i) begin
        sync1[g] <= pin_raw[g];
        sync2[g] <= sync1[g];
      end
    end
  endgenerate

  logic awake;
  assign awake = sync2[SYN_AWAKE];
  assign asleep_o = ~awake;

  // Straps are caught while reset is held; the clock pin is undriven then
  logic rom_present;
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      rom_present <= sync2[SYN_PRESENT];
      big_endian_o <= sync2[SYN_SCLK];
    end
  end

  // Wishbone slave: ack one cycle after request, write lands on the ack edge
  logic wb_req;
  logic wr_fire;
  assign wb_req = wb_cyc_i & wb_stb_i;
  assign wr_fire = wb_req & wb_we_i & wb_ack_o;

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_req & ~wb_ack_o;
    end
  end

  logic [1:0] speed;
  logic [4:0] len;
  logic [31:0] tx_data;
  logic [31:0] ctrl_merged;
  assign ctrl_merged = merge_bytes({19'h0, len, 6'h0, speed}, wb_dat_i, wb_sel_i);

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      speed <= SPEED_RESET;
      len <= LEN_RESET;
    end else if (wr_fire && wb_adr_i == ADDR_CTRL) begin
      speed <= ctrl_merged[CTRL_SPEED_LSB +: 2];
      len <= ctrl_merged[CTRL_LEN_LSB +: 5];
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      tx_data <= TX_RESET;
    end else if (wr_fire && wb_adr_i == ADDR_TX) begin
      tx_data <= merge_bytes(tx_data, wb_dat_i, wb_sel_i);
    end
  end

  logic go;
  logic clr_done;
  logic clr_refused;
  assign go = wr_fire && wb_adr_i == ADDR_CTRL && wb_sel_i[0] && wb_dat_i[CTRL_GO_BIT];
  assign clr_done = wr_fire && wb_adr_i == ADDR_STATUS && wb_sel_i[0]
                    && wb_dat_i[ST_DONE_BIT];
  assign clr_refused = wr_fire && wb_adr_i == ADDR_STATUS && wb_sel_i[0]
                       && wb_dat_i[ST_REFUSED_BIT];

  // Serial engine
  eng_state_t state;
  logic [DIV_W-1:0] div;
  logic [DIV_W-1:0] half_act;
  logic [1:0] speed_act;
  logic [4:0] bits_left;
  logic [31:0] shreg;
  logic [31:0] rx_shift;
  logic [31:0] rx_data;
  logic busy;
  logic half_tick;
  logic done_evt;
  logic refuse_evt;
  logic din_gated;
  assign busy = state != ST_IDLE;
  assign half_act = half_of(speed_act);
  assign half_tick = div == half_act - DIV_W'(1);
  assign done_evt = state == ST_END && half_tick;
  // Absent ROM or sleep refuses a start; so does a start while busy
  assign refuse_evt = go && (!rom_present || !awake || busy);
  assign din_gated = sync2[SYN_DIN] & rom_present;

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      state <= ST_IDLE;
      div <= '0;
      speed_act <= SPEED_RESET;
      bits_left <= '0;
      shreg <= '0;
      rx_shift <= '0;
      serial_rom_clock_o <= 1'b0;
      serial_rom_select_o <= 1'b0;
      serial_rom_data_out_o <= 1'b0;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (go && rom_present && awake) begin
            state <= ST_SHIFT;
            div <= '0;
            // Speed and length written together with the start take effect at once
            speed_act <= ctrl_merged[CTRL_SPEED_LSB +: 2];
            bits_left <= ctrl_merged[CTRL_LEN_LSB +: 5];
            shreg <= tx_data;
            rx_shift <= '0;
            serial_rom_clock_o <= 1'b0;
            serial_rom_select_o <= 1'b1;
            serial_rom_data_out_o <= tx_data[31];
          end
        end
        ST_SHIFT: begin
          if (!awake) begin
            // Sleep aborts mid-word; the ROM sees select drop
            state <= ST_IDLE;
            serial_rom_clock_o <= 1'b0;
            serial_rom_select_o <= 1'b0;
          end else if (half_tick) begin
            div <= '0;
            if (!serial_rom_clock_o) begin
              serial_rom_clock_o <= 1'b1;
              rx_shift <= {rx_shift[30:0], din_gated};
            end else begin
              serial_rom_clock_o <= 1'b0;
              if (bits_left == 5'h0) begin
                state <= ST_END;
              end else begin
                bits_left <= bits_left - 5'h1;
                shreg <= {shreg[30:0], 1'b0};
                serial_rom_data_out_o <= shreg[30];
              end
            end
          end else begin
            div <= div + DIV_W'(1);
          end
        end
        ST_END: begin
          if (half_tick || !awake) begin
            state <= ST_IDLE;
            div <= '0;
            serial_rom_select_o <= 1'b0;
          end else begin
            div <= div + DIV_W'(1);
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      rx_data <= '0;
    end else if (done_evt) begin
      rx_data <= rx_shift;
    end
  end

  // Every pin floats while asleep and in reset; clock pin also floats with no ROM present, for the strap
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      serial_rom_clock_oe_o <= 1'b0;
      serial_rom_select_oe_o <= 1'b0;
      serial_rom_data_out_oe_o <= 1'b0;
    end else begin
      serial_rom_clock_oe_o <= awake & rom_present;
      serial_rom_select_oe_o <= awake;
      serial_rom_data_out_oe_o <= awake;
    end
  end

  // Sticky flags: a set in the clearing cycle wins
  logic done_flag;
  logic refused_flag;
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      done_flag <= 1'b0;
    end else if (done_evt) begin
      done_flag <= 1'b1;
    end else if (clr_done) begin
      done_flag <= 1'b0;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      refused_flag <= 1'b0;
    end else if (refuse_evt) begin
      refused_flag <= 1'b1;
    end else if (clr_refused) begin
      refused_flag <= 1'b0;
    end
  end

  // Host strobes: the write strobe has no relation to our clock, so only
  // its synchronised copy is edge-detected; pulses under 4 ns may be lost
  logic wr_prev;
  logic wr_fall;
  logic [7:0] wr_count;
  logic [7:0] ign_count;
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      wr_prev <= 1'b1;
    end else begin
      wr_prev <= sync2[SYN_WR];
    end
  end
  assign wr_fall = wr_prev & ~sync2[SYN_WR];
  assign chip_enable_o = awake & ~sync2[SYN_QUAL];

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      wr_count <= '0;
      ign_count <= '0;
    end else if (wr_fall && awake) begin
      if (!sync2[SYN_QUAL]) begin
        wr_count <= wr_count + 8'h1;
      end else begin
        ign_count <= ign_count + 8'h1;
      end
    end
  end

  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0;
    unique case (wb_adr_i)
      ADDR_CTRL: begin
        rd_mux[CTRL_SPEED_LSB +: 2] = speed;
        rd_mux[CTRL_LEN_LSB +: 5] = len;
      end
      ADDR_STATUS: begin
        rd_mux[ST_PRESENT_BIT] = rom_present;
        rd_mux[ST_BIG_END_BIT] = big_endian_o;
        rd_mux[ST_BUSY_BIT] = busy;
        rd_mux[ST_DONE_BIT] = done_flag;
        rd_mux[ST_ASLEEP_BIT] = ~awake;
        rd_mux[ST_REFUSED_BIT] = refused_flag;
        rd_mux[ST_WR_CNT_LSB +: 8] = wr_count;
        rd_mux[ST_IGN_CNT_LSB +: 8] = ign_count;
      end
      ADDR_TX: rd_mux = tx_data;
      ADDR_RX: rd_mux = rx_data;
      default: rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      wb_dat_o <= 32'h0;
    end else if (wb_req && !wb_ack_o) begin
      wb_dat_o <= rd_mux;
    end
  end

  // Checking helpers and properties
  logic [DIV_W-1:0] lo_run;
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      lo_run <= '0;
    end else if (busy && !serial_rom_clock_o) begin
      lo_run <= lo_run + DIV_W'(1);
    end else begin
      lo_run <= '0;
    end
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  absent_no_load_a: assert property (!rom_present |-> !busy)
    else $error("engine ran with no ROM present");
  start_when_present_a: assert property (
    go && rom_present && awake && !busy |=> busy && serial_rom_select_o)
    else $error("start request not taken");
  slow_half_a: assert property (
    $rose(serial_rom_clock_o) && speed_act == SPEED_SLOW |-> lo_run == SLOW_HALF)
    else $error("slow serial clock low phase wrong");
  fast_half_a: assert property (
    $rose(serial_rom_clock_o) && speed_act == SPEED_FAST |-> lo_run == FAST_HALF)
    else $error("fast serial clock low phase wrong");
  data_stable_a: assert property (
    $rose(serial_rom_clock_o) |-> $stable(serial_rom_data_out_o))
    else $error("data out moved at clock rise");
  endian_hold_a: assert property ($past(rst_n_i) |-> $stable(big_endian_o))
    else $error("byte order changed after reset");
  din_ignored_a: assert property (!rom_present |=> $stable(rx_data) [*4])
    else $error("receive data moved with no ROM");
  qual_gate_a: assert property (
    wr_fall && awake && sync2[SYN_QUAL] |=> wr_count == $past(wr_count)
    && ign_count == $past(ign_count) + 8'h1)
    else $error("unqualified write was counted");
  sleep_float_a: assert property (!awake |=> !serial_rom_clock_oe_o &&
    !serial_rom_select_oe_o && !serial_rom_data_out_oe_o && !chip_enable_o)
    else $error("pin driven during sleep");

  load_done_c: cover property (done_evt);
  slow_load_c: cover property ($rose(serial_rom_clock_o) && speed_act == SPEED_SLOW);
  refused_c: cover property (refuse_evt);
  host_write_c: cover property (wr_fall && chip_enable_o);

endmodule
